// [core/spfc_ctrl.sv]
// spfc_ctrl: control register, arming windows, page buffer and timing
// of flash self-programming. assumes store/load strobes from the core.
// Notes on behaviour
// - erase, write, lock ops last 3.2-3.4 ms
// - section busy bit always reads zero
// - ready irq while enabled and store idle
// - no ready irq during eeprom or flash op
// - signature arm: load within three returns byte
// - store after signature arm does nothing
// - section re-enable write clears page buffer
// - lock arm: load within three returns lock/fuse
// - page write arm: store programs buffer to page
// - page write bit clears at end or timeout
// - page erase arm: store erases addressed page
// - page erase bit clears at end or timeout
// - core halted during flash operation
// - store enable opens a four-cycle window
// - plain store loads data pair into buffer
// - store enable clears, held during operation
// - only listed command patterns take effect
// - buffer erased after write, re-enable, reset
// - eeprom write blocks commands and fuse reads
// - eeprom write during loading loses buffer
// - programmed fuse bits read zero
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module spfc_ctrl
  import spfc_pkg::*;
#(
  parameter int          PAGE_WORDS = 32,
  parameter int          ZW         = 16,
  parameter int          OP_CYCLES  = spfc_pkg::SPFC_OP_NOM_CYC,
  parameter logic [7:0]  FUSE_LOW   = 8'hE2, // arbitrary
  parameter logic [7:0]  FUSE_HIGH  = 8'hDF, // arbitrary
  parameter logic [7:0]  FUSE_EXT   = 8'hFF, // arbitrary
  parameter logic [7:0]  LOCK_INIT  = 8'hFF,
  parameter logic [31:0] SIG_ROW    = 32'h00A5_5A01 // arbitrary
) (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  input  wire logic [11:0]                   i_paddr,
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [31:0]                   i_pwdata,
  output logic      [31:0]                   o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  input  wire logic                          i_spm_strobe,
  input  wire logic                          i_lpm_strobe,
  input  wire logic [ZW-1:0]                 i_zptr,
  input  wire logic [15:0]                   i_data_pair,
  input  wire logic                          i_global_irq_en,
  input  wire logic                          i_eeprom_write_busy,
  output logic                               o_lpm_take,
  output logic      [7:0]                    o_lpm_data,
  output logic                               o_cpu_halt,
  output logic                               o_ready_irq,
  output logic                               o_flash_start,
  output spfc_pkg::spfc_kind_t               o_flash_kind,
  output logic      [ZW-$clog2(PAGE_WORDS)-2:0] o_flash_page,
  input  wire logic [$clog2(PAGE_WORDS)-1:0] i_buf_idx,
  output logic      [15:0]                   o_buf_word,
  output logic                               o_buf_loaded
);
  import spfc_pkg::*;

  localparam int WB = $clog2(PAGE_WORDS);
  localparam int PB = ZW - WB - 1;

  // ==========================================================
  // apb decode
  logic wr_acc, hit;
  assign hit      = (i_paddr == SPFC_CTRL_ADDR);
  assign wr_acc   = i_psel && i_penable && i_pwrite && hit;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;

  // ==========================================================
  // control state
  spfc_state_t          st_q, st_d;
  logic [SPFC_CMD_W-1:0] cmd_q, cmd_d;
  logic                 irq_en_q, irq_en_d;
  logic [2:0]           win_q, win_d;
  logic [7:0]           lock_bits_q, lock_bits_d;
  logic                 take_q, take_d;
  logic [7:0]           ldata_q, ldata_d;
  logic                 start_q, start_d;
  spfc_kind_t           kind_q, kind_d;
  logic [PB-1:0]        page_q, page_d;
  logic                 ee_q;
  logic                 op_busy, op_done;
  logic                 load_ok, store_we, buf_clr;
  logic [4:0]           wp;
  logic [7:0]           sel_fuse, sel_sig;

  assign wp = i_pwdata[4:0];
  assign load_ok = wr_acc && (st_q != SPFC_ST_OP) && !i_eeprom_write_busy
    && ((!i_pwdata[SPFC_SIG_BIT] && (wp == SPFC_PAT_STORE
          || wp == SPFC_PAT_ERASE || wp == SPFC_PAT_WRITE
          || wp == SPFC_PAT_LOCK  || wp == SPFC_PAT_REEN))
        || (i_pwdata[SPFC_SIG_BIT] && wp == SPFC_PAT_STORE));

  // fuse and lock values are stored in read-back polarity
  always_comb begin
    case (i_zptr[1:0])
      2'h0:    sel_fuse = FUSE_LOW;
      2'h1:    sel_fuse = lock_bits_q;
      2'h2:    sel_fuse = FUSE_EXT;
      default: sel_fuse = FUSE_HIGH;
    endcase
    sel_sig = SIG_ROW[8*i_zptr[1:0] +: 8];
  end

  always_comb begin
    st_d        = st_q;
    cmd_d       = cmd_q;
    irq_en_d    = irq_en_q;
    win_d       = win_q;
    lock_bits_d = lock_bits_q;
    take_d      = 1'b0;
    ldata_d     = ldata_q;
    start_d     = 1'b0;
    kind_d      = kind_q;
    page_d      = page_q;
    store_we    = 1'b0;
    if (wr_acc) begin
      irq_en_d = i_pwdata[SPFC_IRQ_EN_BIT];
    end
    case (st_q)
      SPFC_ST_IDLE, SPFC_ST_ARMED: begin
        if (load_ok) begin
          cmd_d = i_pwdata[SPFC_CMD_W-1:0];
          win_d = SPFC_SPM_WINDOW;
          st_d  = SPFC_ST_ARMED;
        end else if (st_q == SPFC_ST_ARMED) begin
          // eeprom write blocks store and load
          if (i_spm_strobe && !i_eeprom_write_busy) begin
            st_d   = SPFC_ST_IDLE;
            cmd_d  = '0;
            page_d = i_zptr[ZW-1:WB+1];
            // signature and re-enable stores do nothing
            if (!cmd_q[SPFC_SIG_BIT]) begin
              case (cmd_q[4:0])
                SPFC_PAT_STORE: store_we = 1'b1;
                SPFC_PAT_ERASE: begin
                  kind_d = SPFC_KIND_ERASE;
                  start_d = 1'b1;
                end
                SPFC_PAT_WRITE: begin
                  kind_d = SPFC_KIND_WRITE;
                  start_d = 1'b1;
                end
                SPFC_PAT_LOCK: begin
                  kind_d = SPFC_KIND_LOCK;
                  start_d = 1'b1;
                  lock_bits_d = lock_bits_q & i_data_pair[7:0];
                end
                default: ;
              endcase
            end
            if (start_d) begin
              st_d  = SPFC_ST_OP;
              cmd_d = cmd_q;
            end
          end else if (i_lpm_strobe && !i_eeprom_write_busy
                       && win_q >= SPFC_LPM_MIN_CNT
                       && (cmd_q[SPFC_SIG_BIT]
                           || cmd_q[4:0] == SPFC_PAT_LOCK)) begin
            take_d  = 1'b1;
            ldata_d = cmd_q[SPFC_SIG_BIT] ? sel_sig : sel_fuse;
            st_d    = SPFC_ST_IDLE;
            cmd_d   = '0;
          end else if (win_q == SPFC_CNT_LAST) begin
            st_d  = SPFC_ST_IDLE;
            cmd_d = '0;
          end else begin
            win_d = win_q - 1'b1;
          end
        end
      end
      SPFC_ST_OP: begin
        if (op_done) begin
          st_d  = SPFC_ST_IDLE;
          cmd_d = '0;
        end
      end
      default: begin
        st_d  = SPFC_ST_IDLE;
        cmd_d = '0;
      end
    endcase
  end

  // reset clears commands, enable and window
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q        <= SPFC_ST_IDLE;
      cmd_q       <= SPFC_CTRL_RESET[SPFC_CMD_W-1:0];
      irq_en_q    <= SPFC_CTRL_RESET[SPFC_IRQ_EN_BIT];
      win_q       <= '0;
      lock_bits_q <= LOCK_INIT;
      take_q      <= 1'b0;
      ldata_q     <= '0;
      start_q     <= 1'b0;
      kind_q      <= SPFC_KIND_ERASE;
      page_q      <= '0;
      ee_q        <= 1'b0;
    end else begin
      st_q        <= st_d;
      cmd_q       <= cmd_d;
      irq_en_q    <= irq_en_d;
      win_q       <= win_d;
      lock_bits_q <= lock_bits_d;
      take_q      <= take_d;
      ldata_q     <= ldata_d;
      start_q     <= start_d;
      kind_q      <= kind_d;
      page_q      <= page_d;
      ee_q        <= i_eeprom_write_busy;
    end
  end

  // ==========================================================
  // operation timing
  // one fixed count within the allowed span
  spfc_op_timer #(
    .CYCLES (OP_CYCLES)
  ) u_timer (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_start (start_q),
    .o_busy  (op_busy),
    .o_done  (op_done)
  );

  // ==========================================================
  // page buffer
  logic [15:0]           buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] loaded_q, loaded_d;
  logic [WB-1:0]         widx;
  assign widx = i_zptr[WB:1];

  assign buf_clr = (load_ok && !i_pwdata[SPFC_SIG_BIT]
                    && wp == SPFC_PAT_REEN)
                || (op_done && kind_q == SPFC_KIND_WRITE)
                || (i_eeprom_write_busy && !ee_q && |loaded_q);

  genvar gi;
  generate
    for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_word
      // one write per word between clears
      always_comb begin
        loaded_d[gi] = buf_clr ? 1'b0
          : loaded_q[gi] | (store_we && widx == WB'(gi));
      end
      always_ff @(posedge i_mclk) begin
        if (store_we && widx == WB'(gi) && !loaded_q[gi]) begin
          buf_mem[gi] <= i_data_pair;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      loaded_q     <= '0;
      o_buf_word   <= '0;
      o_buf_loaded <= 1'b0;
    end else begin
      loaded_q     <= loaded_d;
      o_buf_word   <= buf_mem[i_buf_idx];
      o_buf_loaded <= loaded_q[i_buf_idx];
    end
  end

  // ==========================================================
  // outputs
  // busy bit is constant zero, no separate partition here
  assign o_prdata = (i_psel && hit)
    ? {24'h000000, irq_en_q, 1'b0, cmd_q} : 32'h0000_0000;
  // halt core for the whole operation
  assign o_cpu_halt = op_busy || start_q;
  assign o_ready_irq = irq_en_q && i_global_irq_en && !cmd_q[0]
    && !i_eeprom_write_busy && !op_busy;
  assign o_lpm_take    = take_q;
  assign o_lpm_data    = ldata_q;
  assign o_flash_start = start_q;
  assign o_flash_kind  = kind_q;
  assign o_flash_page  = page_q;

  // ==========================================================
  // checks
  int unsigned busy_len_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst || !op_busy) busy_len_q <= 0;
    else busy_len_q <= busy_len_q + 1;
  end

  property p_op_len;
    @(posedge i_mclk) disable iff (i_rst)
      $fell(op_busy) |-> busy_len_q == OP_CYCLES;
  endproperty
  a_op_len: assert property (p_op_len)
    else $error("flash op length wrong");

  property p_busy_zero;
    @(posedge i_mclk) disable iff (i_rst)
      i_psel |-> !o_prdata[SPFC_BUSY_BIT];
  endproperty
  a_busy_zero: assert property (p_busy_zero)
    else $error("section busy bit read as one");

  property p_irq_on;
    @(posedge i_mclk) disable iff (i_rst)
      irq_en_q && i_global_irq_en && !o_prdata[0] && st_q == SPFC_ST_IDLE
      && !i_eeprom_write_busy && !op_busy && i_psel |-> o_ready_irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("ready irq missing");

  property p_irq_off;
    @(posedge i_mclk) disable iff (i_rst)
      (i_eeprom_write_busy || o_cpu_halt) |-> !o_ready_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("ready irq during busy");

  property p_lpm;
    @(posedge i_mclk) disable iff (i_rst)
      st_q == SPFC_ST_ARMED && win_q >= SPFC_LPM_MIN_CNT && cmd_q[SPFC_SIG_BIT]
      && i_lpm_strobe && !i_spm_strobe && !i_eeprom_write_busy && !load_ok
      |=> o_lpm_take && o_lpm_data == $past(sel_sig);
  endproperty
  a_lpm: assert property (p_lpm)
    else $error("signature byte not returned");

  property p_sig_store;
    @(posedge i_mclk) disable iff (i_rst)
      st_q == SPFC_ST_ARMED && cmd_q[SPFC_SIG_BIT] && i_spm_strobe
      |=> !o_flash_start && $stable(loaded_q);
  endproperty
  a_sig_store: assert property (p_sig_store)
    else $error("store after signature arm acted");

  property p_window;
    @(posedge i_mclk) disable iff (i_rst)
      load_ok ##1 (!i_spm_strobe && !i_lpm_strobe && !wr_acc)[*4]
      |=> st_q == SPFC_ST_IDLE && cmd_q == '0;
  endproperty
  a_window: assert property (p_window)
    else $error("arming window did not expire");

  property p_hold;
    @(posedge i_mclk) disable iff (i_rst)
      op_busy |-> o_cpu_halt && cmd_q[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("halt or store enable dropped in op");

  property p_ee_block;
    @(posedge i_mclk) disable iff (i_rst)
      wr_acc && i_eeprom_write_busy && st_q == SPFC_ST_IDLE
      |=> st_q == SPFC_ST_IDLE;
  endproperty
  a_ee_block: assert property (p_ee_block)
    else $error("command armed during eeprom write");

  c_erase: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_flash_start && o_flash_kind == SPFC_KIND_ERASE);
  c_store: cover property (@(posedge i_mclk) disable iff (i_rst) store_we);
  c_lock: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_lpm_take && !$past(cmd_q[SPFC_SIG_BIT]));
endmodule // spfc_ctrl
`default_nettype wire

// [core/spfc_op_timer.sv]
// spfc_op_timer: fixed-length timer for one flash erase, write or lock.
// assumes i_start is only pulsed while the timer is idle.
`timescale 1ns/1ps
`default_nettype none
module spfc_op_timer #(
  parameter int CYCLES = 330000
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] cnt_q, cnt_d;
  logic          busy_q, busy_d;
  logic          done_q, done_d;

  // ==========================================================
  // countdown
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (!busy_q && i_start) begin
      cnt_d  = LOAD;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == ZERO) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_q  <= ZERO;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule // spfc_op_timer
`default_nettype wire

// [core/spfc_pkg.sv]
// spfc_pkg: constants and types of the self-programming flash control.
// assumes a 100 MHz core clock and a byte-wide control register on APB.
package spfc_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] SPFC_CTRL_ADDR   = 12'h000;
  localparam logic [7:0]  SPFC_CTRL_RESET  = 8'h00;
  localparam int          SPFC_IRQ_EN_BIT  = 7;
  localparam int          SPFC_BUSY_BIT    = 6;
  localparam int          SPFC_SIG_BIT     = 5;
  localparam int          SPFC_CMD_W       = 6;

  // ==========================================================
  // accepted command patterns, low five bits
  localparam logic [4:0]  SPFC_PAT_STORE   = 5'h01;
  localparam logic [4:0]  SPFC_PAT_ERASE   = 5'h03;
  localparam logic [4:0]  SPFC_PAT_WRITE   = 5'h05;
  localparam logic [4:0]  SPFC_PAT_LOCK    = 5'h09;
  localparam logic [4:0]  SPFC_PAT_REEN    = 5'h11;

  // ==========================================================
  // arming windows in core cycles after the register write
  localparam logic [2:0]  SPFC_SPM_WINDOW  = 3'h4;
  localparam logic [2:0]  SPFC_LPM_MIN_CNT = 3'h2;
  localparam logic [2:0]  SPFC_CNT_LAST    = 3'h1;

  // ==========================================================
  // flash operation time
  localparam int  SPFC_CLK_MHZ    = 100;
  localparam real SPFC_OP_MIN_MS  = 3.2;
  localparam real SPFC_OP_MAX_MS  = 3.4;
  localparam int  SPFC_OP_MIN_CYC =
    int'($ceil(SPFC_OP_MIN_MS * 1000.0 * SPFC_CLK_MHZ));
  localparam int  SPFC_OP_MAX_CYC =
    int'($floor(SPFC_OP_MAX_MS * 1000.0 * SPFC_CLK_MHZ));
  localparam int  SPFC_OP_NOM_CYC = (SPFC_OP_MIN_CYC + SPFC_OP_MAX_CYC) / 2;

  typedef enum logic [1:0] {
    SPFC_KIND_ERASE = 2'h0,
    SPFC_KIND_WRITE = 2'h1,
    SPFC_KIND_LOCK  = 2'h2
  } spfc_kind_t;

  typedef enum logic [2:0] {
    SPFC_ST_IDLE  = 3'b001,
    SPFC_ST_ARMED = 3'b010,
    SPFC_ST_OP    = 3'b100
  } spfc_state_t;

endpackage

// [verif/spfc_cpu_model.sv]
// spfc_cpu_model: core side issuing store and load program strobes.
// assumes the control block stalls it through i_halt.
`timescale 1ns/1ps
`default_nettype none
module spfc_cpu_model (
  input  wire logic        i_mclk,
  input  wire logic        i_halt,
  input  wire logic        i_take,
  input  wire logic [7:0]  i_data,
  output logic             o_spm,
  output logic             o_lpm,
  output logic      [15:0] o_zptr,
  output logic      [15:0] o_pair
);
  initial begin
    o_spm  = 1'b0;
    o_lpm  = 1'b0;
    o_zptr = 16'h0000;
    o_pair = 16'h0000;
  end

  // ==========================================================
  // instructions
  // no instruction while halted
  task automatic wait_run();
    while (i_halt === 1'b1) @(posedge i_mclk);
  endtask

  task automatic store(input logic [15:0] z, input logic [15:0] d);
    wait_run();
    o_spm  <= 1'b1;
    o_zptr <= z;
    o_pair <= d;
    @(posedge i_mclk);
    o_spm  <= 1'b0;
    o_zptr <= ~z;
    o_pair <= ~d;
  endtask

  task automatic load(input logic [15:0] z, output logic tk,
                      output logic [7:0] v);
    wait_run();
    o_lpm  <= 1'b1;
    o_zptr <= z;
    @(posedge i_mclk);
    o_lpm  <= 1'b0;
    o_zptr <= ~z;
    #1;
    tk = i_take;
    v  = i_data;
  endtask
endmodule // spfc_cpu_model
`default_nettype wire

// [verif/testbench.sv]
// testbench: drives spfc_ctrl over APB and through the core model.
// assumes a short OP_CYCLES; expectations come from the bench model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spfc_pkg::*;
  localparam int          OPC  = 20;
  localparam logic [7:0]  F_LO = 8'h5A; // arbitrary
  localparam logic [7:0]  F_HI = 8'hC3; // arbitrary
  localparam logic [7:0]  F_EX = 8'hF6; // arbitrary
  localparam logic [7:0]  LK0  = 8'hFF;
  localparam logic [31:0] SIG  = 32'h1E2D_3C4B; // arbitrary
  logic        i_mclk, i_rst, psel, penable, pwrite, pready, pslverr;
  logic        gie, eeb, spm, lpm, take, halt, irq, start, bload;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] zptr, pair, bword, z, d;
  logic [7:0]  ldat, ie, lk, v;
  logic [4:0]  bidx;
  logic [9:0]  page;
  logic        er, tk;
  spfc_kind_t  kind;
  logic [15:0] mw [32];
  logic        ml [32];
  int          fails, checked, seed, n;

  spfc_ctrl #(.OP_CYCLES(OPC), .FUSE_LOW(F_LO), .FUSE_HIGH(F_HI),
    .FUSE_EXT(F_EX), .LOCK_INIT(LK0), .SIG_ROW(SIG)) i_spfc_ctrl (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_spm_strobe(spm), .i_lpm_strobe(lpm), .i_zptr(zptr),
    .i_data_pair(pair), .i_global_irq_en(gie),
    .i_eeprom_write_busy(eeb), .o_lpm_take(take), .o_lpm_data(ldat),
    .o_cpu_halt(halt), .o_ready_irq(irq), .o_flash_start(start),
    .o_flash_kind(kind), .o_flash_page(page), .i_buf_idx(bidx),
    .o_buf_word(bword), .o_buf_loaded(bload));

  spfc_cpu_model i_spfc_cpu_model (
    .i_mclk(i_mclk), .i_halt(halt), .i_take(take), .i_data(ldat),
    .o_spm(spm), .o_lpm(lpm), .o_zptr(zptr), .o_pair(pair));

  always #5 i_mclk = ~i_mclk;

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] wd);
    @(posedge i_mclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h0, wd};
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~pwdata;
  endtask

  task automatic wr(input logic [7:0] x);
    apb(1'b1, SPFC_CTRL_ADDR, x | ie);
  endtask

  task automatic rdc(input logic [7:0] e);
    apb(1'b0, SPFC_CTRL_ADDR, 8'h00);
    check(rd, {24'h0, e | ie});
  endtask

  task automatic lchk(input logic [15:0] zz, input logic et,
                      input logic [7:0] ev);
    i_spfc_cpu_model.load(zz, tk, v);
    check({31'h0, tk}, {31'h0, et});
    if (et) check({24'h0, v}, {24'h0, ev});
  endtask

  task automatic put(input logic [15:0] zz, input logic [15:0] dd);
    i_spfc_cpu_model.store(zz, dd);
    if (!ml[zz[5:1]]) begin
      mw[zz[5:1]] = dd;
      ml[zz[5:1]] = 1'b1;
    end
  endtask

  task automatic chk_buf();
    for (int k = 0; k < 32; k++) begin
      @(posedge i_mclk);
      bidx <= k[4:0];
      @(posedge i_mclk);
      #1;
      check({31'h0, bload}, {31'h0, ml[k]}); // one write per word
      if (ml[k]) check({16'h0, bword}, {16'h0, mw[k]}); // data
    end
  endtask

  task automatic clr();
    foreach (ml[k]) ml[k] = 1'b0;
  endtask

  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    i_mclk = 1'b0; i_rst = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; gie = 1'b1;
    eeb = 1'b0; bidx = 5'h00; ie = 8'h00; lk = LK0;
    seed = 32'h061adc69;
    clr();
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    rdc(8'h00); // cleared by reset
    apb(1'b0, 12'h004, 8'h00);
    check({31'h0, er}, 32'h1); // unmapped address refused
    chk_buf(); // empty after reset
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      z = 16'($random(seed));
      d = 16'($random(seed));
      wr(8'h01);
      put(z, d);
      rdc(8'h00); // store enable self-clears
    end
    chk_buf(); // words placed by pointer
    wr(8'h11);
    clr();
    chk_buf(); // re-enable clears buffer
    $display("test page load done");
    wr(8'h01);
    repeat (3) @(posedge i_mclk);
    put(16'h0003, 16'hBEEF); // last edge of window
    wr(8'h01);
    repeat (4) @(posedge i_mclk);
    i_spfc_cpu_model.store(16'h0004, 16'h1234); // too late
    wr(8'h01);
    wr(8'h01);
    repeat (3) @(posedge i_mclk);
    put(16'h0006, 16'h7E57); // rewrite restarts window
    wr(8'h01);
    put(16'h0002, 16'h0BAD); // loaded word keeps first data
    wr(8'h05);
    repeat (4) @(posedge i_mclk);
    rdc(8'h00); // page write arm expires
    wr(8'h03);
    repeat (4) @(posedge i_mclk);
    rdc(8'h00); // page erase arm expires
    wr(8'h21);
    i_spfc_cpu_model.store(16'h000A, 16'hDEAD); // no effect
    chk_buf(); // window bounds
    $display("test windows done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h09);
      lchk(16'(i), 1'b1, (i == 0) ? F_LO : (i == 1) ? LK0 :
           (i == 2) ? F_EX : F_HI); // lock or fuse byte
      wr(8'h21);
      lchk(16'(i), 1'b1, SIG[8*i +: 8]); // signature byte
    end
    wr(8'h09);
    repeat (3) @(posedge i_mclk);
    lchk(16'h0001, 1'b0, 8'h00); // three-cycle window
    $display("test reads done");
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h07 : (i == 1) ? 8'h0B : (i == 2) ? 8'h13 :
          (i == 3) ? 8'h02 : 8'h1D;
      wr(v);
      rdc(8'h00); // ignored pattern
    end
    check({31'h0, irq}, 32'h0); // enable bit clear
    ie = 8'h80;
    apb(1'b1, SPFC_CTRL_ADDR, 8'hC0);
    rdc(8'h00); // busy bit reads zero
    check({31'h0, irq}, 32'h1); // request while idle
    $display("test patterns done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h03 : (i == 1) ? 8'h05 : 8'h09;
      z = 16'($random(seed));
      z[5:0] = 6'h00;
      d = 16'($random(seed));
      wr(v);
      i_spfc_cpu_model.store(z, d);
      #1;
      check({31'h0, start}, 32'h1); // operation launched
      check(32'(kind), 32'(i)); // kind of operation
      check({22'h0, page}, {22'h0, z[15:6]}); // upper pointer bits
      check({31'h0, halt}, 32'h1); // core halted
      check({31'h0, irq}, 32'h0); // no request during op
      rdc(v); // held during op
      n = 3;
      while (halt === 1'b1 && n < 1000) begin
        @(posedge i_mclk);
        n++;
      end
      check({31'h0, n >= OPC && n <= OPC + 3}, 32'h1); // op length
      // poll busy and store enable before next command
      rdc(8'h00); // command bits clear at end
      if (i == 1) clr();
      if (i == 2) lk = lk & d[7:0];
    end
    chk_buf(); // cleared after page write
    wr(8'h09);
    lchk(16'h0001, 1'b1, lk); // programmed bits read zero
    $display("test operations done");
    wr(8'h01);
    put(16'h0010, 16'hA5A5);
    @(posedge i_mclk);
    eeb <= 1'b1;
    @(posedge i_mclk);
    #1;
    check({31'h0, irq}, 32'h0); // eeprom write masks request
    clr();
    chk_buf(); // eeprom write loses buffer
    wr(8'h01);
    rdc(8'h00); // command blocked
    @(posedge i_mclk);
    eeb <= 1'b0;
    gie <= 1'b0;
    @(posedge i_mclk);
    #1;
    check({31'h0, irq}, 32'h0); // global enable off
    // timed sequence with irqs masked and eeprom idle
    wr(8'h01);
    put(16'h0012, 16'h5AA5);
    chk_buf(); // store lands under masked irqs
    $display("test eeprom done");
    results();
  end
endmodule // testbench
`default_nettype wire
